// ==== design/prhs_defines.svh ====
// Constants for the packet route and header strip block.
// Assumes inclusion by bare name from the design folder.
`ifndef PRHS_DEFINES_SVH
`define PRHS_DEFINES_SVH

// ------------------------------------------------------------
// Widths and depths
// ------------------------------------------------------------
`define PRHS_DATA_W    8
`define PRHS_PORT_W    5
`define PRHS_NUM_PORTS 32
`define PRHS_NUM_CHAN  32
`define PRHS_TBL_DEPTH 256
`define PRHS_IV_DEPTH  8
`define PRHS_IV_IDX_W  3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PRHS_RST_PORT  5'h00
`define PRHS_RST_BYTE  8'h00

`endif

// ==== design/prhs_pkg.sv ====
// Types shared by the packet route and header strip files.
// Assumes nothing of its surroundings.
package prhs_pkg;

  // ------------------------------------------------------------
  // Addressing schemes selected by the mode input
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PRHS_DIRECT,
    PRHS_LOGICAL,
    PRHS_REGIONAL,
    PRHS_INTERVAL
  } prhs_mode_t;

  // ------------------------------------------------------------
  // Packet handling states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HEAD,
    ST_WAIT,
    ST_SEND_HDR,
    ST_FWD,
    ST_DROP
  } prhs_state_t;

endpackage : prhs_pkg

// ==== design/prhs_lookup.sv ====
// Routing table and interval table storage with combinational lookup.
// Assumes the tables are loaded before traffic arrives.
`timescale 1ns/10ps
`default_nettype none
`include "prhs_defines.svh"

module prhs_lookup #(
  parameter int DEPTH    = `PRHS_TBL_DEPTH,
  parameter int IV_DEPTH = `PRHS_IV_DEPTH
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        tbl_wr,
  input  wire logic [`PRHS_DATA_W-1:0]     tbl_addr,
  input  wire logic [`PRHS_PORT_W-1:0]     tbl_port,
  input  wire logic                        tbl_del,
  input  wire logic                        tbl_valid,
  input  wire logic                        iv_wr,
  input  wire logic [`PRHS_IV_IDX_W-1:0]   iv_idx,
  input  wire logic [`PRHS_DATA_W-1:0]     iv_lo,
  input  wire logic [`PRHS_DATA_W-1:0]     iv_hi,
  input  wire logic [`PRHS_PORT_W-1:0]     iv_port,
  input  wire logic                        iv_valid,
  input  wire logic [`PRHS_DATA_W-1:0]     key,
  output logic      [`PRHS_PORT_W-1:0]     log_port,
  output logic                             log_del,
  output logic                             log_hit,
  output logic      [`PRHS_PORT_W-1:0]     ivl_port,
  output logic                             ivl_hit
);
  import prhs_pkg::*;

  logic [`PRHS_PORT_W-1:0] port_ff [DEPTH];
  logic [DEPTH-1:0]        del_ff;
  logic [DEPTH-1:0]        val_ff;
  logic [`PRHS_PORT_W-1:0] nxt_port [DEPTH];
  logic [DEPTH-1:0]        nxt_del;
  logic [DEPTH-1:0]        nxt_val;
  logic [`PRHS_DATA_W-1:0] lo_ff [IV_DEPTH];
  logic [`PRHS_DATA_W-1:0] hi_ff [IV_DEPTH];
  logic [`PRHS_PORT_W-1:0] ivp_ff [IV_DEPTH];
  logic [IV_DEPTH-1:0]     ivv_ff;
  logic [`PRHS_DATA_W-1:0] nxt_lo [IV_DEPTH];
  logic [`PRHS_DATA_W-1:0] nxt_hi [IV_DEPTH];
  logic [`PRHS_PORT_W-1:0] nxt_ivp [IV_DEPTH];
  logic [IV_DEPTH-1:0]     nxt_ivv;

  function automatic logic in_span(input logic [`PRHS_DATA_W-1:0] v,
                                   input logic [`PRHS_DATA_W-1:0] lo,
                                   input logic [`PRHS_DATA_W-1:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

  // ------------------------------------------------------------
  // Table updates
  // ------------------------------------------------------------
  always_comb begin
    nxt_port = port_ff;
    nxt_del  = del_ff;
    nxt_val  = val_ff;
    nxt_lo   = lo_ff;
    nxt_hi   = hi_ff;
    nxt_ivp  = ivp_ff;
    nxt_ivv  = ivv_ff;
    if (tbl_wr) begin
      nxt_port[tbl_addr] = tbl_port;
      nxt_del[tbl_addr]  = tbl_del;
      nxt_val[tbl_addr]  = tbl_valid;
    end
    if (iv_wr) begin
      nxt_lo[iv_idx]  = iv_lo;
      nxt_hi[iv_idx]  = iv_hi;
      nxt_ivp[iv_idx] = iv_port;
      nxt_ivv[iv_idx] = iv_valid;
    end
    if (rst) begin
      nxt_val = '0;
      nxt_del = '0;
      nxt_ivv = '0;
      for (int i = 0; i < DEPTH; i++) begin
        nxt_port[i] = `PRHS_RST_PORT;
      end
      for (int j = 0; j < IV_DEPTH; j++) begin
        nxt_lo[j]  = `PRHS_RST_BYTE;
        nxt_hi[j]  = `PRHS_RST_BYTE;
        nxt_ivp[j] = `PRHS_RST_PORT;
      end
    end
  end

  always_ff @(posedge clk) begin
    port_ff <= nxt_port;
    del_ff  <= nxt_del;
    val_ff  <= nxt_val;
    lo_ff   <= nxt_lo;
    hi_ff   <= nxt_hi;
    ivp_ff  <= nxt_ivp;
    ivv_ff  <= nxt_ivv;
  end

  // ------------------------------------------------------------
  // Lookups; the lowest matching interval wins
  // ------------------------------------------------------------
  always_comb begin
    log_port = port_ff[key];
    log_del  = del_ff[key];
    log_hit  = val_ff[key];
    ivl_port = `PRHS_RST_PORT;
    ivl_hit  = 1'b0;
    for (int k = IV_DEPTH - 1; k >= 0; k--) begin
      if (ivv_ff[k] && in_span(key, lo_ff[k], hi_ff[k])) begin
        ivl_port = ivp_ff[k];
        ivl_hit  = 1'b1;
      end
    end
  end

endmodule : prhs_lookup
`default_nettype wire

// ==== design/prhs_top.sv ====
// Route decision and header deletion for one input of a packet switch or node.
// Assumes a character stream with end markers and a shared port busy vector.
//
// How it works
// - The leading byte of each packet chooses the output port.
// - With deletion on, the leading byte is dropped and the rest forwarded, except in regional mode.
// - In node mode the leading byte names the destination channel.
// - In node mode the leading byte is always removed before delivery.
// - Direct mode uses the leading byte itself as the port number.
// - Logical mode looks the leading byte up in a routing table.
// - Table entries are independent; many addresses may share one port.
// - Each table entry carries its own header deletion flag.
// - Regional mode strips the region byte when that entry says delete.
// - Interval mode maps contiguous address ranges to one port each.
// - The first data byte after EOP or EEP is the next leading byte.
// - An allocated port stays busy until the end marker has gone out.
`timescale 1ns/10ps
`default_nettype none
`include "prhs_defines.svh"

module prhs_top #(
  parameter int NUM_PORTS = `PRHS_NUM_PORTS,
  parameter int NUM_CHAN  = `PRHS_NUM_CHAN
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire prhs_pkg::prhs_mode_t        route_mode,
  input  wire logic                        hdr_del_en,
  input  wire logic                        node_mode,
  input  wire logic [NUM_CHAN-1:0]         chan_active,
  input  wire logic                        tbl_wr,
  input  wire logic [`PRHS_DATA_W-1:0]     tbl_addr,
  input  wire logic [`PRHS_PORT_W-1:0]     tbl_port,
  input  wire logic                        tbl_del,
  input  wire logic                        tbl_valid,
  input  wire logic                        iv_wr,
  input  wire logic [`PRHS_IV_IDX_W-1:0]   iv_idx,
  input  wire logic [`PRHS_DATA_W-1:0]     iv_lo,
  input  wire logic [`PRHS_DATA_W-1:0]     iv_hi,
  input  wire logic [`PRHS_PORT_W-1:0]     iv_port,
  input  wire logic                        iv_valid,
  input  wire logic [NUM_PORTS-1:0]        port_busy,
  input  wire logic                        in_valid,
  input  wire logic [`PRHS_DATA_W-1:0]     in_data,
  input  wire logic                        in_eop,
  input  wire logic                        in_eep,
  output logic                             in_ready,
  output logic                             out_valid,
  output logic      [`PRHS_DATA_W-1:0]     out_data,
  output logic                             out_eop,
  output logic                             out_eep,
  output logic      [`PRHS_PORT_W-1:0]     out_port,
  input  wire logic                        out_ready,
  output logic                             alloc_busy,
  output logic      [`PRHS_PORT_W-1:0]     alloc_port,
  output logic                             drop_pulse
);
  import prhs_pkg::*;

  prhs_state_t             state_ff;
  prhs_state_t             nxt_state;
  logic [`PRHS_DATA_W-1:0] hdr_ff;
  logic [`PRHS_DATA_W-1:0] nxt_hdr;
  logic [`PRHS_PORT_W-1:0] port_ff;
  logic [`PRHS_PORT_W-1:0] nxt_port;
  logic                    del_ff;
  logic                    nxt_del;
  logic                    busy_ff;
  logic                    nxt_busy;
  logic                    drop_ff;
  logic                    nxt_drop;
  logic                    ov_ff;
  logic                    nxt_ov;
  logic [`PRHS_DATA_W-1:0] od_ff;
  logic [`PRHS_DATA_W-1:0] nxt_od;
  logic                    oeop_ff;
  logic                    nxt_oeop;
  logic                    oeep_ff;
  logic                    nxt_oeep;
  logic [`PRHS_PORT_W-1:0] op_ff;
  logic [`PRHS_PORT_W-1:0] nxt_op;
  logic [`PRHS_PORT_W-1:0] log_port;
  logic                    log_del;
  logic                    log_hit;
  logic [`PRHS_PORT_W-1:0] ivl_port;
  logic                    ivl_hit;
  logic [`PRHS_PORT_W-1:0] dec_port;
  logic                    dec_del;
  logic                    dec_hit;
  logic                    in_mark;
  logic                    in_take;
  logic                    can_load;
  logic                    mark_out;

  function automatic logic below(input logic [`PRHS_DATA_W-1:0] v, input int lim);
    below = (int'(v) < lim);
  endfunction : below

  prhs_lookup u_lookup (
    .clk       (clk),
    .rst       (rst),
    .tbl_wr    (tbl_wr),
    .tbl_addr  (tbl_addr),
    .tbl_port  (tbl_port),
    .tbl_del   (tbl_del),
    .tbl_valid (tbl_valid),
    .iv_wr     (iv_wr),
    .iv_idx    (iv_idx),
    .iv_lo     (iv_lo),
    .iv_hi     (iv_hi),
    .iv_port   (iv_port),
    .iv_valid  (iv_valid),
    .key       (in_data),
    .log_port  (log_port),
    .log_del   (log_del),
    .log_hit   (log_hit),
    .ivl_port  (ivl_port),
    .ivl_hit   (ivl_hit)
  );

  // ------------------------------------------------------------
  // Leading byte decode
  // ------------------------------------------------------------
  always_comb begin
    dec_port = in_data[`PRHS_PORT_W-1:0];
    dec_del  = hdr_del_en;
    dec_hit  = below(in_data, NUM_PORTS);
    if (node_mode) begin
      dec_hit = below(in_data, NUM_CHAN) && chan_active[in_data[`PRHS_PORT_W-1:0]];
      dec_del = 1'b1;
    end else begin
      case (route_mode)
        PRHS_DIRECT: begin
          dec_hit = below(in_data, NUM_PORTS);
        end
        PRHS_LOGICAL: begin
          dec_port = log_port;
          dec_hit  = log_hit && below({3'h0, log_port}, NUM_PORTS);
        end
        PRHS_REGIONAL: begin
          dec_port = log_port;
          dec_del  = log_del;
          dec_hit  = log_hit && below({3'h0, log_port}, NUM_PORTS);
        end
        PRHS_INTERVAL: begin
          dec_port = ivl_port;
          dec_hit  = ivl_hit && below({3'h0, ivl_port}, NUM_PORTS);
        end
        default: begin
          dec_hit = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Packet state and output stage
  // ------------------------------------------------------------
  assign in_mark  = in_eop || in_eep;
  assign can_load = !ov_ff || out_ready;
  assign mark_out = ov_ff && out_ready && (oeop_ff || oeep_ff);
  assign in_take  = in_valid && in_ready;

  always_comb begin
    case (state_ff)
      ST_HEAD:  in_ready = 1'b1;
      ST_DROP:  in_ready = 1'b1;
      ST_FWD:   in_ready = can_load;
      default:  in_ready = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_hdr   = hdr_ff;
    nxt_port  = port_ff;
    nxt_del   = del_ff;
    nxt_busy  = busy_ff;
    nxt_drop  = 1'b0;
    nxt_ov    = ov_ff && !out_ready;
    nxt_od    = od_ff;
    nxt_oeop  = oeop_ff;
    nxt_oeep  = oeep_ff;
    nxt_op    = op_ff;
    if (mark_out) begin
      nxt_busy = 1'b0;
    end
    case (state_ff)
      ST_HEAD: begin
        if (in_take && !in_mark) begin
          nxt_hdr  = in_data;
          nxt_port = dec_port;
          nxt_del  = dec_del;
          nxt_state = dec_hit ? ST_WAIT : ST_DROP;
        end
      end
      ST_WAIT: begin
        if (!busy_ff && !port_busy[port_ff]) begin
          nxt_busy  = 1'b1;
          nxt_state = del_ff ? ST_FWD : ST_SEND_HDR;
        end
      end
      ST_SEND_HDR: begin
        if (can_load) begin
          nxt_ov    = 1'b1;
          nxt_od    = hdr_ff;
          nxt_oeop  = 1'b0;
          nxt_oeep  = 1'b0;
          nxt_op    = port_ff;
          nxt_state = ST_FWD;
        end
      end
      ST_FWD: begin
        if (in_take) begin
          nxt_ov   = 1'b1;
          nxt_od   = in_data;
          nxt_oeop = in_eop;
          nxt_oeep = in_eep;
          nxt_op   = port_ff;
          if (in_mark) begin
            nxt_state = ST_HEAD;
          end
        end
      end
      ST_DROP: begin
        if (in_take && in_mark) begin
          nxt_drop  = 1'b1;
          nxt_state = ST_HEAD;
        end
      end
      default: begin
        nxt_state = ST_HEAD;
      end
    endcase
    if (rst) begin
      nxt_state = ST_HEAD;
      nxt_hdr   = `PRHS_RST_BYTE;
      nxt_port  = `PRHS_RST_PORT;
      nxt_del   = 1'b0;
      nxt_busy  = 1'b0;
      nxt_drop  = 1'b0;
      nxt_ov    = 1'b0;
      nxt_od    = `PRHS_RST_BYTE;
      nxt_oeop  = 1'b0;
      nxt_oeep  = 1'b0;
      nxt_op    = `PRHS_RST_PORT;
    end
  end

  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
    hdr_ff   <= nxt_hdr;
    port_ff  <= nxt_port;
    del_ff   <= nxt_del;
    busy_ff  <= nxt_busy;
    drop_ff  <= nxt_drop;
    ov_ff    <= nxt_ov;
    od_ff    <= nxt_od;
    oeop_ff  <= nxt_oeop;
    oeep_ff  <= nxt_oeep;
    op_ff    <= nxt_op;
  end

  assign out_valid  = ov_ff;
  assign out_data   = od_ff;
  assign out_eop    = oeop_ff;
  assign out_eep    = oeep_ff;
  assign out_port   = op_ff;
  assign alloc_busy = busy_ff;
  assign alloc_port = port_ff;
  assign drop_pulse = drop_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  head_decide_a: assert property (
    state_ff == ST_HEAD && in_valid && !in_mark |=> state_ff inside {ST_WAIT, ST_DROP})
    else $error("leading byte did not produce a decision");
  direct_port_a: assert property (
    state_ff == ST_HEAD && in_valid && !in_mark && !node_mode && route_mode == PRHS_DIRECT
      && below(in_data, NUM_PORTS) |=> state_ff == ST_WAIT && port_ff == $past(in_data[`PRHS_PORT_W-1:0]))
    else $error("direct port number not taken from leading byte");
  node_strip_a: assert property (
    state_ff == ST_HEAD && in_valid && !in_mark && node_mode |=> del_ff)
    else $error("node mode did not mark header for removal");
  hdr_sent_a: assert property (
    state_ff == ST_SEND_HDR && can_load |=> ov_ff && od_ff == hdr_ff && state_ff == ST_FWD)
    else $error("kept header not forwarded first");
  del_skip_a: assert property (
    state_ff == ST_WAIT && del_ff && !busy_ff && !port_busy[port_ff] |=> state_ff == ST_FWD)
    else $error("deleted header was not skipped");
  busy_hold_a: assert property (
    busy_ff && !mark_out |=> busy_ff)
    else $error("port released before end marker left");
  busy_free_a: assert property (
    mark_out |=> !busy_ff)
    else $error("port not released after end marker");
  next_head_a: assert property (
    state_ff == ST_FWD && in_take && in_mark |=> state_ff == ST_HEAD)
    else $error("end marker did not rearm leading byte");
  miss_drop_a: assert property (
    state_ff == ST_DROP && in_take && in_mark |=> drop_pulse ##1 !drop_pulse)
    else $error("discard did not end with one pulse");

  cov_strip_c: cover property (state_ff == ST_WAIT ##1 state_ff == ST_FWD);
  cov_keep_c:  cover property (state_ff == ST_SEND_HDR ##1 state_ff == ST_FWD);
  cov_drop_c:  cover property (drop_pulse);
  cov_wait_c:  cover property (state_ff == ST_WAIT [*3]);

endmodule : prhs_top
`default_nettype wire

// ==== sim/prhs_sink.sv ====
// Downstream partner: a receiver that takes characters from the block.
// Assumes the bench sets slow off the falling edge of clk.
`timescale 1ns/10ps
`default_nettype none

module prhs_sink (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_eop,
  input  wire logic       out_eep,
  input  wire logic [4:0] out_port,
  output logic            out_ready
);
  logic [14:0] got_q[$];
  int          tick;

  // ------------------------------------------------------------
  // Accept and record
  // ------------------------------------------------------------
  // Slow mode accepts one cycle in three, so the block must hold its output.
  initial begin
    out_ready = 1'b1;
    tick = 0;
  end
  always @(negedge clk) begin
    tick = tick + 1;
    out_ready = !slow || (tick % 3 == 0);
  end
  // End markers carry no data, so their data field is recorded as zero.
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready)
      got_q.push_back({out_eop, out_eep, out_port, (out_eop | out_eep) ? 8'h00 : out_data});
  end
endmodule : prhs_sink
`default_nettype wire

// ==== sim/test_packet_route_header_strip.sv ====
// Self-checking bench for the packet route and header strip block.
// Assumes prhs_pkg, prhs_top and prhs_sink are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module test_packet_route_header_strip;
  import prhs_pkg::*;
  prhs_mode_t  mode;
  logic        clk, rst, del_en, node, tbl_wr, tbl_del, tbl_valid, iv_wr, iv_valid, slow;
  logic [31:0] chan, busy;
  logic [7:0]  tbl_addr, iv_lo, iv_hi, in_data, out_data;
  logic [4:0]  tbl_port, iv_port, out_port, alloc_port;
  logic [2:0]  iv_idx;
  logic        in_valid, in_eop, in_eep, in_ready, out_valid, out_eop, out_eep, out_ready;
  logic        alloc_busy, drop_pulse;
  logic [14:0] exp_q[$];
  int          bad_count, n_checks, drops;

  prhs_top DUT (.clk(clk), .rst(rst), .route_mode(mode), .hdr_del_en(del_en), .node_mode(node),
    .chan_active(chan), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr), .tbl_port(tbl_port), .tbl_del(tbl_del),
    .tbl_valid(tbl_valid), .iv_wr(iv_wr), .iv_idx(iv_idx), .iv_lo(iv_lo), .iv_hi(iv_hi),
    .iv_port(iv_port), .iv_valid(iv_valid), .port_busy(busy), .in_valid(in_valid), .in_data(in_data),
    .in_eop(in_eop), .in_eep(in_eep), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_eop(out_eop), .out_eep(out_eep), .out_port(out_port), .out_ready(out_ready),
    .alloc_busy(alloc_busy), .alloc_port(alloc_port), .drop_pulse(drop_pulse));
  prhs_sink sink (.clk(clk), .slow(slow), .out_valid(out_valid), .out_data(out_data), .out_eop(out_eop),
    .out_eep(out_eep), .out_port(out_port), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  always @(posedge clk) if (drop_pulse === 1'b1) drops <= drops + 1;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  // Holds a character until the block takes it.
  task put(input logic [7:0] d, input logic e, input logic x);
    logic ok;
    int   k;
    @(negedge clk);
    in_valid = 1'b1;
    in_data = d;
    in_eop = e;
    in_eep = x;
    for (k = 0; k < 300; k++) begin
      #19;
      ok = in_ready;
      @(posedge clk);
      if (ok === 1'b1) break;
      @(negedge clk);
    end
    if (k == 300) check(0, 1);
  endtask : put

  task pkt(input logic [7:0] b[$], input logic x);
    foreach (b[i]) put(b[i], 1'b0, 1'b0);
    put(8'h00, !x, x);
  endtask : pkt

  task want(input logic [4:0] p, input logic [7:0] b[$], input logic x);
    foreach (b[i]) exp_q.push_back({2'b00, p, b[i]});
    exp_q.push_back({!x, x, p, 8'h00});
  endtask : want

  // Waits for the expected characters, then compares them all.
  task drain();
    int k;
    @(negedge clk);
    in_valid = 1'b0;
    for (k = 0; k < 300 && sink.got_q.size() < exp_q.size(); k++) @(posedge clk);
    repeat (6) @(posedge clk);
    check(sink.got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < sink.got_q.size())
      check(sink.got_q[i], exp_q[i]);
    sink.got_q.delete();
    exp_q.delete();
  endtask : drain

  task tbl(input logic [7:0] a, input logic [4:0] p, input logic d);
    @(negedge clk);
    {tbl_wr, tbl_addr, tbl_port, tbl_del, tbl_valid} = {1'b1, a, p, d, 1'b1};
    @(negedge clk);
    tbl_wr = 1'b0;
  endtask : tbl

  task ivl(input logic [2:0] i, input logic [7:0] lo, input logic [7:0] hi, input logic [4:0] p);
    @(negedge clk);
    {iv_wr, iv_idx, iv_lo, iv_hi, iv_port, iv_valid} = {1'b1, i, lo, hi, p, 1'b1};
    @(negedge clk);
    iv_wr = 1'b0;
  endtask : ivl

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task s_direct();
    mode = PRHS_DIRECT;
    want(5'h02, '{8'h02, 8'hA1, 8'hA2}, 1'b0);
    pkt('{8'h02, 8'hA1, 8'hA2}, 1'b0);
    drain();
  endtask : s_direct

  // A stray marker first, then two packets back to back into a stalling sink.
  task s_delete();
    del_en = 1'b1;
    slow = 1'b1;
    put(8'h00, 1'b1, 1'b0);
    want(5'h03, '{8'hB1, 8'hB2}, 1'b0);
    want(5'h05, '{8'hC1}, 1'b1);
    pkt('{8'h03, 8'hB1, 8'hB2}, 1'b0);
    pkt('{8'h05, 8'hC1}, 1'b1);
    drain();
    slow = 1'b0;
    del_en = 1'b0;
  endtask : s_delete

  task s_logical();
    logic [4:0] lp[4];
    lp = '{5'h08, 5'h01, 5'h03, 5'h01};
    mode = PRHS_LOGICAL;
    for (int a = 1; a <= 4; a++) tbl(8'(a), lp[a-1], 1'b0);
    for (int a = 1; a <= 4; a++) begin
      want(lp[a-1], '{8'(a), 8'(8'hF0 + a)}, 1'b0);
      pkt('{8'(a), 8'(8'hF0 + a)}, 1'b0);
    end
    drain();
  endtask : s_logical

  // Global deletion is on, yet the entry flag alone decides.
  task s_regional();
    mode = PRHS_REGIONAL;
    del_en = 1'b1;
    tbl(8'h09, 5'h04, 1'b1);
    tbl(8'h0A, 5'h06, 1'b0);
    want(5'h04, '{8'h0A, 8'hD1}, 1'b0);
    pkt('{8'h09, 8'h0A, 8'hD1}, 1'b0);
    want(5'h06, '{8'h0A, 8'hD2}, 1'b0);
    pkt('{8'h0A, 8'hD2}, 1'b0);
    drain();
  endtask : s_regional

  task s_interval();
    logic [7:0] ia[6];
    logic [4:0] ip[6];
    ia = '{8'h01, 8'h03, 8'h04, 8'h09, 8'h0A, 8'h20};
    ip = '{5'h07, 5'h07, 5'h02, 5'h02, 5'h09, 5'h09};
    mode = PRHS_INTERVAL;
    ivl(3'h0, 8'h01, 8'h03, 5'h07);
    ivl(3'h1, 8'h04, 8'h09, 5'h02);
    ivl(3'h2, 8'h0A, 8'h20, 5'h09);
    for (int i = 0; i < 6; i++) begin
      want(ip[i], '{ia[i]}, 1'b0);
      pkt('{ia[i], ia[i]}, 1'b0);
    end
    drain();
  endtask : s_interval

  // Bad port, empty table entry and an address outside every interval.
  task s_drop();
    del_en = 1'b0;
    drops = 0;
    mode = PRHS_DIRECT;
    pkt('{8'h40, 8'h11}, 1'b0);
    mode = PRHS_LOGICAL;
    pkt('{8'h77, 8'h12}, 1'b1);
    mode = PRHS_INTERVAL;
    pkt('{8'h21, 8'h13}, 1'b0);
    drain();
    check(drops, 3);
  endtask : s_drop

  task s_node();
    node = 1'b1;
    drops = 0;
    chan = 32'h0000_0020;
    want(5'h05, '{8'hE1, 8'hE2}, 1'b0);
    pkt('{8'h05, 8'hE1, 8'hE2}, 1'b0);
    pkt('{8'h06, 8'hE3}, 1'b0);
    drain();
    check(drops, 1);
    node = 1'b0;
  endtask : s_node

  // The wanted port is held elsewhere, then freed while the sink stalls.
  task s_busy();
    mode = PRHS_DIRECT;
    busy = 32'h0000_0004;
    slow = 1'b1;
    want(5'h02, '{8'h02, 8'hA5, 8'hA6, 8'hA7}, 1'b0);
    fork
      pkt('{8'h02, 8'hA5, 8'hA6, 8'hA7}, 1'b0);
      begin
        repeat (20) @(posedge clk);
        check(alloc_busy, 0);
        check(sink.got_q.size(), 0);
        @(negedge clk);
        busy = 32'h0;
        for (int k = 0; k < 100 && sink.got_q.size() == 0; k++) @(posedge clk);
        check(alloc_busy, 1);
        check(alloc_port, 5'h02);
      end
    join
    drain();
    check(alloc_busy, 0);
    slow = 1'b0;
  endtask : s_busy

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    mode = PRHS_DIRECT;
    {rst, del_en, node, chan, busy, slow} = {1'b1, 67'h0};
    {tbl_wr, tbl_addr, tbl_port, tbl_del, tbl_valid} = 16'h0;
    {iv_wr, iv_idx, iv_lo, iv_hi, iv_port, iv_valid} = 26'h0;
    {in_valid, in_data, in_eop, in_eep} = 11'h0;
    {bad_count, n_checks, drops} = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check({in_ready, out_valid, alloc_busy, drop_pulse}, 4'h8);
    s_direct();
    s_delete();
    s_logical();
    s_regional();
    s_interval();
    s_drop();
    s_node();
    s_busy();
    tally_and_finish();
  end

  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_packet_route_header_strip
`default_nettype wire
